// file: rtl/gcu_global_ctrl.sv
`timescale 1ns/100ps
module gcu_global_ctrl
    import gcu_pkg::*;
#(
    parameter int NUM_PORTS = GCU_NUM_PORTS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Strap
    input wire logic strap_led_high_i,
    // Frame decision
    input wire logic frm_valid_i,
    input wire logic frm_oam_i,
    input wire logic frm_crc_err_i,
    input wire logic frm_undersize_i,
    input wire logic frm_oversize_i,
    output logic frm_loop_o,
    output logic frm_drop_o,
    // Core controls
    output logic phy_power_save_o,
    output logic test_mode_o,
    output logic [1:0] loopback_mode_select_o,
    output logic indicator_select_low_o,
    output logic indicator_select_high_o,
    // Port status
    input wire logic [NUM_PORTS-1:0] link_i,
    input wire logic [NUM_PORTS-1:0] act_i,
    input wire logic [NUM_PORTS-1:0] fdx_i,
    input wire logic [NUM_PORTS-1:0] col_i,
    input wire logic [NUM_PORTS-1:0] spd100_i,
    // Lamps
    output logic [NUM_PORTS-1:0] port_lamp_zero_o,
    output logic [NUM_PORTS-1:0] port_lamp_one_o,
    output logic [NUM_PORTS-1:0] port_lamp_two_o,
    output logic [NUM_PORTS-1:0] port_lamp_three_o
);
    typedef struct packed {
        logic [7:0] factory;
        logic power_save;
        logic err_drop;
        logic test_bit;
        logic [1:0] lb_mode;
        logic led_low;
        logic rsvd_lo;
        logic [7:0] user1;
        logic [7:0] user2;
        logic [7:0] user3;
        logic strap_taken;
        logic strap_high;
        logic [7:0] rdata;
        logic loop_p;
        logic drop_p;
    } gcu_state_t;

    gcu_state_t st_ff;
    gcu_state_t nxt_st;
    logic [7:0] ctrl_word;
    logic frm_err;

    // Readback of the control register; top bit reads zero
    always_comb begin
        ctrl_word = '0;
        ctrl_word[GCU_BIT_PWR_SAVE] = st_ff.power_save;
        ctrl_word[GCU_BIT_ERR_DROP] = st_ff.err_drop;
        ctrl_word[GCU_BIT_TEST] = st_ff.test_bit;
        ctrl_word[GCU_BIT_LB_HI:GCU_BIT_LB_LO] = st_ff.lb_mode;
        ctrl_word[GCU_BIT_LED_LOW] = st_ff.led_low;
        ctrl_word[GCU_BIT_RSVD_LO] = st_ff.rsvd_lo;
    end

    assign frm_err = frm_crc_err_i | frm_undersize_i | frm_oversize_i;

    always_comb begin
        nxt_st = st_ff;
        // Strap caught once, on the first edge after reset release
        if (!st_ff.strap_taken) begin
            nxt_st.strap_taken = 1'b1;
            nxt_st.strap_high = strap_led_high_i;
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                GCU_ADDR_FACTORY: nxt_st.factory = reg_wdata_i;
                GCU_ADDR_LBLED: begin
                    nxt_st.power_save = reg_wdata_i[GCU_BIT_PWR_SAVE];
                    nxt_st.err_drop = reg_wdata_i[GCU_BIT_ERR_DROP];
                    nxt_st.test_bit = reg_wdata_i[GCU_BIT_TEST];
                    nxt_st.lb_mode = reg_wdata_i[GCU_BIT_LB_HI:GCU_BIT_LB_LO];
                    nxt_st.led_low = reg_wdata_i[GCU_BIT_LED_LOW];
                    nxt_st.rsvd_lo = reg_wdata_i[GCU_BIT_RSVD_LO];
                end
                GCU_ADDR_USER1: nxt_st.user1 = reg_wdata_i;
                GCU_ADDR_USER2: nxt_st.user2 = reg_wdata_i;
                GCU_ADDR_USER3: nxt_st.user3 = reg_wdata_i;
                default: nxt_st.rsvd_lo = st_ff.rsvd_lo;
            endcase
        end
        // Read data shows stored state before any same-cycle write
        if (reg_rd_i) begin
            case (reg_addr_i)
                GCU_ADDR_FACTORY: nxt_st.rdata = st_ff.factory;
                GCU_ADDR_LBLED: nxt_st.rdata = ctrl_word;
                GCU_ADDR_RSVD: nxt_st.rdata = GCU_RST_RSVD;
                GCU_ADDR_USER1: nxt_st.rdata = st_ff.user1;
                GCU_ADDR_USER2: nxt_st.rdata = st_ff.user2;
                GCU_ADDR_USER3: nxt_st.rdata = st_ff.user3;
                default: nxt_st.rdata = '0;
            endcase
        end
        // Loopback filtering: OAM always dropped, errors only with err_drop
        nxt_st.drop_p = frm_valid_i & (frm_oam_i | (st_ff.err_drop & frm_err));
        nxt_st.loop_p = frm_valid_i & ~frm_oam_i & ~(st_ff.err_drop & frm_err);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.factory <= GCU_RST_FACTORY;
            st_ff.lb_mode <= GCU_RST_LB_MODE;
            st_ff.power_save <= GCU_RST_BIT;
            st_ff.user1 <= GCU_RST_USER;
            st_ff.user2 <= GCU_RST_USER;
            st_ff.user3 <= GCU_RST_USER;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign frm_loop_o = st_ff.loop_p;
    assign frm_drop_o = st_ff.drop_p;
    assign phy_power_save_o = st_ff.power_save;
    assign test_mode_o = st_ff.test_bit;
    assign loopback_mode_select_o = st_ff.lb_mode;
    assign indicator_select_low_o = st_ff.led_low;
    assign indicator_select_high_o = st_ff.strap_high;

    gcu_lamp_mux #(
        .NUM_PORTS(NUM_PORTS)
    ) u_lamp (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sel_i({st_ff.strap_high, st_ff.led_low}),
        .link_i(link_i),
        .act_i(act_i),
        .fdx_i(fdx_i),
        .col_i(col_i),
        .spd100_i(spd100_i),
        .port_lamp_zero_o(port_lamp_zero_o),
        .port_lamp_one_o(port_lamp_one_o),
        .port_lamp_two_o(port_lamp_two_o),
        .port_lamp_three_o(port_lamp_three_o)
    );

    // Checks
    a_drop_errored: assert property (@(posedge clock_i) disable iff (rst_i)
        frm_valid_i && st_ff.err_drop && frm_err |=> frm_drop_o && !frm_loop_o)
        else $error("errored frame not dropped with err_drop set");
    a_loop_errored: assert property (@(posedge clock_i) disable iff (rst_i)
        frm_valid_i && !st_ff.err_drop && !frm_oam_i |=> frm_loop_o && !frm_drop_o)
        else $error("frame not looped with err_drop clear");
    a_oam_dropped: assert property (@(posedge clock_i) disable iff (rst_i)
        frm_valid_i && frm_oam_i |=> frm_drop_o && !frm_loop_o)
        else $error("OAM frame not dropped");
    a_loop_good: assert property (@(posedge clock_i) disable iff (rst_i)
        frm_valid_i && !frm_oam_i && !frm_err |=> frm_loop_o)
        else $error("good frame not looped");
    a_strap_fixed: assert property (@(posedge clock_i) disable iff (rst_i)
        st_ff.strap_taken |=> $stable(indicator_select_high_o))
        else $error("high indicator select changed after strap capture");
    a_led_low_wr: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_LBLED
        |=> indicator_select_low_o == $past(reg_wdata_i[GCU_BIT_LED_LOW]))
        else $error("low indicator select not taken from write");
    a_user_rdback: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_USER2 ##1
        reg_rd_i && reg_addr_i == GCU_ADDR_USER2 && !reg_wr_i
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("user byte two readback mismatch");
    a_factory_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        !(reg_wr_i && reg_addr_i == GCU_ADDR_FACTORY) |=> $stable(st_ff.factory))
        else $error("factory byte changed without a write");
    a_pwr_save_wr: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_LBLED
        |=> phy_power_save_o == $past(reg_wdata_i[GCU_BIT_PWR_SAVE]))
        else $error("power save not taken from write");
    a_rsvd_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_rd_i && (reg_addr_i == GCU_ADDR_RSVD || reg_addr_i == GCU_ADDR_LBLED)
        |=> reg_rdata_o[GCU_BIT_RSVD_HI] == 1'b0)
        else $error("reserved bit read nonzero");
    a_frm_one_verdict: assert property (@(posedge clock_i) disable iff (rst_i)
        frm_valid_i |=> frm_loop_o != frm_drop_o)
        else $error("frame not given exactly one verdict");
    a_frm_idle_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
        !frm_valid_i |=> !frm_loop_o && !frm_drop_o)
        else $error("loop or drop pulse without a frame");
    a_factory_wr: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_FACTORY |=> st_ff.factory == $past(reg_wdata_i))
        else $error("factory byte not taken from write");
    a_user_one_wr: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_USER1 |=> st_ff.user1 == $past(reg_wdata_i))
        else $error("user byte one not taken from write");
    a_user_three_wr: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == GCU_ADDR_USER3 |=> st_ff.user3 == $past(reg_wdata_i))
        else $error("user byte three not taken from write");
    a_rdata_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    a_rsvd_read: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == GCU_ADDR_RSVD |=> reg_rdata_o == GCU_RST_RSVD)
        else $error("reserved register read nonzero");
    a_lamp_three_off: assert property (@(posedge clock_i) disable iff (rst_i)
        !(indicator_select_high_o && !indicator_select_low_o) |=> port_lamp_three_o == '0)
        else $error("lamp three lit outside its selection");
endmodule : gcu_global_ctrl

// file: rtl/gcu_pkg.sv
package gcu_pkg;
    // Register addresses of this slice
    localparam logic [7:0] GCU_ADDR_FACTORY = 8'h0A;
    localparam logic [7:0] GCU_ADDR_LBLED = 8'h0B;
    localparam logic [7:0] GCU_ADDR_RSVD = 8'h0C;
    localparam logic [7:0] GCU_ADDR_USER1 = 8'h0D;
    localparam logic [7:0] GCU_ADDR_USER2 = 8'h0E;
    localparam logic [7:0] GCU_ADDR_USER3 = 8'h0F;

    // Reset values
    localparam logic [7:0] GCU_RST_FACTORY = 8'h24;
    localparam logic [7:0] GCU_RST_USER = 8'h00;
    localparam logic [7:0] GCU_RST_RSVD = 8'h00;
    localparam logic [1:0] GCU_RST_LB_MODE = 2'h2;
    localparam logic GCU_RST_BIT = 1'h0;

    // Field positions of the loopback and LED control register
    localparam int GCU_BIT_RSVD_HI = 7;
    localparam int GCU_BIT_PWR_SAVE = 6;
    localparam int GCU_BIT_ERR_DROP = 5;
    localparam int GCU_BIT_TEST = 4;
    localparam int GCU_BIT_LB_HI = 3;
    localparam int GCU_BIT_LB_LO = 2;
    localparam int GCU_BIT_LED_LOW = 1;
    localparam int GCU_BIT_RSVD_LO = 0;

    // Indicator selection codes {high, low}
    localparam logic [1:0] GCU_LED_SEL_00 = 2'h0;
    localparam logic [1:0] GCU_LED_SEL_01 = 2'h1;
    localparam logic [1:0] GCU_LED_SEL_10 = 2'h2;

    localparam int GCU_NUM_PORTS = 3;
endpackage : gcu_pkg

// file: rtl/gcu_lamp_mux.sv
`timescale 1ns/100ps
module gcu_lamp_mux
    import gcu_pkg::*;
#(
    parameter int NUM_PORTS = GCU_NUM_PORTS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Selection
    input wire logic [1:0] sel_i,
    // Port status
    input wire logic [NUM_PORTS-1:0] link_i,
    input wire logic [NUM_PORTS-1:0] act_i,
    input wire logic [NUM_PORTS-1:0] fdx_i,
    input wire logic [NUM_PORTS-1:0] col_i,
    input wire logic [NUM_PORTS-1:0] spd100_i,
    // Lamps, lit when high
    output logic [NUM_PORTS-1:0] port_lamp_zero_o,
    output logic [NUM_PORTS-1:0] port_lamp_one_o,
    output logic [NUM_PORTS-1:0] port_lamp_two_o,
    output logic [NUM_PORTS-1:0] port_lamp_three_o
);
    typedef struct packed {
        logic [NUM_PORTS-1:0] l0;
        logic [NUM_PORTS-1:0] l1;
        logic [NUM_PORTS-1:0] l2;
        logic [NUM_PORTS-1:0] l3;
    } gcu_lamp_t;

    gcu_lamp_t st_ff;
    gcu_lamp_t nxt_st;

    always_comb begin
        nxt_st = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            case (sel_i)
                GCU_LED_SEL_00: begin
                    nxt_st.l2[p] = link_i[p] & ~act_i[p];
                    nxt_st.l1[p] = fdx_i[p] | col_i[p];
                    nxt_st.l0[p] = spd100_i[p];
                end
                GCU_LED_SEL_01: begin
                    nxt_st.l2[p] = link_i[p] & ~act_i[p] & spd100_i[p];
                    nxt_st.l1[p] = link_i[p] & ~act_i[p] & ~spd100_i[p];
                    nxt_st.l0[p] = fdx_i[p];
                end
                GCU_LED_SEL_10: begin
                    nxt_st.l3[p] = act_i[p];
                    nxt_st.l2[p] = link_i[p];
                    nxt_st.l1[p] = fdx_i[p] | col_i[p];
                    nxt_st.l0[p] = spd100_i[p];
                end
                default: begin
                    nxt_st.l0[p] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign port_lamp_zero_o = st_ff.l0;
    assign port_lamp_one_o = st_ff.l1;
    assign port_lamp_two_o = st_ff.l2;
    assign port_lamp_three_o = st_ff.l3;
endmodule : gcu_lamp_mux

// file: tb/gcu_global_ctrl_tb.sv
`timescale 1ns/100ps
module gcu_global_ctrl_tb;
    import gcu_pkg::*;
    typedef struct packed {
        logic ed; logic oam; logic crc; logic und; logic ovr; logic loop; logic drop;
    } gcu_frm_row_t;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic strap_led_high_i = 1'b0;
    logic frm_valid_i = 1'b0;
    logic frm_oam_i = 1'b0;
    logic frm_crc_err_i = 1'b0;
    logic frm_undersize_i = 1'b0;
    logic frm_oversize_i = 1'b0;
    logic frm_loop_o, frm_drop_o, phy_power_save_o, test_mode_o;
    logic indicator_select_low_o, indicator_select_high_o;
    logic [1:0] loopback_mode_select_o;
    logic [2:0] link_i = 3'h5, act_i = 3'h1, fdx_i = 3'h2, col_i = 3'h4, spd100_i = 3'h6;
    logic [2:0] port_lamp_zero_o, port_lamp_one_o, port_lamp_two_o, port_lamp_three_o;
    int mismatches = 0;
    int checks_done = 0;
    gcu_frm_row_t rows [10] = '{
        7'h42, 7'h51, 7'h49, 7'h45, 7'h61,
        7'h02, 7'h12, 7'h06, 7'h21, 7'h71};

    gcu_global_ctrl #(.NUM_PORTS(3)) gcu_global_ctrl_inst (
        .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .strap_led_high_i(strap_led_high_i), .frm_valid_i(frm_valid_i),
        .frm_oam_i(frm_oam_i), .frm_crc_err_i(frm_crc_err_i),
        .frm_undersize_i(frm_undersize_i), .frm_oversize_i(frm_oversize_i),
        .frm_loop_o(frm_loop_o), .frm_drop_o(frm_drop_o),
        .phy_power_save_o(phy_power_save_o), .test_mode_o(test_mode_o),
        .loopback_mode_select_o(loopback_mode_select_o),
        .indicator_select_low_o(indicator_select_low_o),
        .indicator_select_high_o(indicator_select_high_o), .link_i(link_i), .act_i(act_i),
        .fdx_i(fdx_i), .col_i(col_i), .spd100_i(spd100_i),
        .port_lamp_zero_o(port_lamp_zero_o), .port_lamp_one_o(port_lamp_one_o),
        .port_lamp_two_o(port_lamp_two_o), .port_lamp_three_o(port_lamp_three_o));

    always #2 clock_i = ~clock_i;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic do_reset(input logic strap);
        @(negedge clock_i);
        rst_i = 1'b1;
        strap_led_high_i = strap;
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask : do_reset

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        reg_addr_i = addr;
        reg_wdata_i = data;
        reg_wr_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clock_i);
        reg_addr_i = addr;
        reg_rd_i = 1'b1;
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk(name, exp, reg_rdata_o);
    endtask : rd

    task automatic lamps(input logic [11:0] exp);
        repeat (3) @(negedge clock_i);
        chk("lamp3", {5'h00, exp[11:9]}, {5'h00, port_lamp_three_o});
        chk("lamp2", {5'h00, exp[8:6]}, {5'h00, port_lamp_two_o});
        chk("lamp1", {5'h00, exp[5:3]}, {5'h00, port_lamp_one_o});
        chk("lamp0", {5'h00, exp[2:0]}, {5'h00, port_lamp_zero_o});
    endtask : lamps

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        do_reset(1'b0);
        chk("lb_mode", {6'h00, GCU_RST_LB_MODE}, {6'h00, loopback_mode_select_o});
        chk("pwr_save", 8'h00, {7'h00, phy_power_save_o});
        chk("test_mode", 8'h00, {7'h00, test_mode_o});
        chk("sel_high", 8'h00, {7'h00, indicator_select_high_o});
        rd("factory", GCU_ADDR_FACTORY, 8'h24);
        rd("ctrl", GCU_ADDR_LBLED, 8'h08);
        for (int i = 0; i < 3; i++) begin
            rd("user", GCU_ADDR_USER1 + 8'(i), 8'h00);
            wr(GCU_ADDR_USER1 + 8'(i), 8'hA5 ^ 8'(i));
        end
        for (int i = 0; i < 3; i++) begin
            rd("user", GCU_ADDR_USER1 + 8'(i), 8'hA5 ^ 8'(i));
        end
        wr(GCU_ADDR_FACTORY, 8'h5A);
        rd("factory", GCU_ADDR_FACTORY, 8'h5A);
        wr(GCU_ADDR_RSVD, 8'hFF);
        rd("rsvd", GCU_ADDR_RSVD, 8'h00);
        rd("unmapped", 8'h20, 8'h00);
        wr(GCU_ADDR_LBLED, 8'hC8);
        chk("pwr_save", 8'h01, {7'h00, phy_power_save_o});
        chk("lb_mode", 8'h02, {6'h00, loopback_mode_select_o});
        chk("test_mode", 8'h00, {7'h00, test_mode_o});
        rd("ctrl", GCU_ADDR_LBLED, 8'h48);
        foreach (rows[i]) begin
            wr(GCU_ADDR_LBLED, rows[i].ed ? 8'h28 : 8'h08);
            @(negedge clock_i);
            {frm_oam_i, frm_crc_err_i, frm_undersize_i, frm_oversize_i} = rows[i][5:2];
            frm_valid_i = 1'b1;
            @(negedge clock_i);
            frm_valid_i = 1'b0;
            chk("loop", {7'h00, rows[i].loop}, {7'h00, frm_loop_o});
            chk("drop", {7'h00, rows[i].drop}, {7'h00, frm_drop_o});
            @(negedge clock_i);
            chk("pulse", 8'h00, {6'h00, frm_loop_o, frm_drop_o});
        end
        wr(GCU_ADDR_LBLED, 8'h08);
        lamps({3'h0, 3'h4, 3'h6, 3'h6});
        wr(GCU_ADDR_LBLED, 8'h0A);
        chk("sel_low", 8'h01, {7'h00, indicator_select_low_o});
        lamps({3'h0, 3'h4, 3'h0, 3'h2});
        // Write and read together, then the read alone in the next cycle
        @(negedge clock_i);
        reg_addr_i = GCU_ADDR_USER2;
        reg_wdata_i = 8'h3C;
        reg_wr_i = 1'b1;
        reg_rd_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        chk("same_cycle", 8'hA4, reg_rdata_o);
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk("next_cycle", 8'h3C, reg_rdata_o);
        rd("user", GCU_ADDR_USER2, 8'h3C);
        do_reset(1'b1);
        chk("sel_high", 8'h01, {7'h00, indicator_select_high_o});
        chk("sel_low", 8'h00, {7'h00, indicator_select_low_o});
        // Strap moves after capture; the high select must not follow
        strap_led_high_i = 1'b0;
        rd("user", GCU_ADDR_USER2, 8'h00);
        lamps({3'h1, 3'h5, 3'h6, 3'h6});
        chk("sel_high", 8'h01, {7'h00, indicator_select_high_o});
        wr(GCU_ADDR_LBLED, 8'h0A);
        chk("sel_high", 8'h01, {7'h00, indicator_select_high_o});
        lamps(12'h000);
        complete_run();
    end
endmodule : gcu_global_ctrl_tb
